/* File: include/tprs_regs.svh */
// tprs_regs.svh: register offsets, field positions, reset values and timing counts
// assumes a 40 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef TPRS_REGS_SVH
`define TPRS_REGS_SVH

// register byte offsets
`define TPRS_CTRL_OFS        8'h00
`define TPRS_STATUS_OFS      8'h04
`define TPRS_SENS_OFS        8'h08
`define TPRS_STEP_OFS        8'h0C
`define TPRS_TICK_OFS        8'h10

// control fields (write 1 to act; every bit but the start bit is a level)
`define TPRS_CTRL_RESET_BIT  0
`define TPRS_CTRL_SKIP_BIT   1
`define TPRS_CTRL_START_BIT  2
`define TPRS_CTRL_MREC_BIT   3
`define TPRS_CTRL_MRUN_BIT   4

// status fields
`define TPRS_ST_PWR_BIT      0
`define TPRS_ST_ARM_BIT      1
`define TPRS_ST_RUN_BIT      2
`define TPRS_ST_XPORT_BIT    3
`define TPRS_ST_REC_BIT      4
`define TPRS_ST_CAL_BIT      5

// reset values
`define TPRS_CTRL_RST        32'h0000_0000
`define TPRS_SENS_RST        3'h0

// time base: one tick every 1 ms at 40 MHz
`define TPRS_CLK_HZ          40000000
`define TPRS_TICK_MS         1
`define TPRS_TICK_CYC        ((`TPRS_CLK_HZ / 1000) * `TPRS_TICK_MS)

// sequence times in seconds, minutes and milliseconds, converted to ticks
`define TPRS_ARM_S           5
`define TPRS_REC_MIN         13
`define TPRS_CAL_MS          500
`define TPRS_PULSE_MS        200
`define TPRS_ARM_TICKS       (`TPRS_ARM_S * 1000 / `TPRS_TICK_MS)
`define TPRS_REC_TICKS       (`TPRS_REC_MIN * 60 * 1000 / `TPRS_TICK_MS)
`define TPRS_CAL_TICKS       (`TPRS_CAL_MS / `TPRS_TICK_MS)
`define TPRS_PULSE_TICKS     (`TPRS_PULSE_MS / `TPRS_TICK_MS)

// gain ratio denominators per sensitivity setting: 1,2,4,6,8,10
`define TPRS_SENS_SETTINGS   6

`endif

/* File: include/tprs_pkg.sv */
// tprs_pkg: types of the two-pulse record sequencer
// assumes nothing beyond a SystemVerilog compiler
package tprs_pkg;

    // program timer steps, one-hot
    typedef enum logic [10:0] {
        TPRS_IDLE     = 11'h001,
        TPRS_WARM     = 11'h002,
        TPRS_START    = 11'h004,
        TPRS_RECORD   = 11'h008,
        TPRS_CAL1_ON  = 11'h010,
        TPRS_CAL1_OFF = 11'h020,
        TPRS_RUNNING  = 11'h040,
        TPRS_CAL2_ON  = 11'h080,
        TPRS_CAL2_OFF = 11'h100,
        TPRS_STOP     = 11'h200,
        TPRS_UNLATCH  = 11'h400
    } tprs_step_e;

endpackage : tprs_pkg

/* File: rtl/tprs_tick.sv */
// tprs_tick: slow time base divider producing a one-cycle tick
// assumes aclk at the rate in tprs_regs.svh and a synchronous active-low reset
`timescale 1ns/1ps
`include "tprs_regs.svh"

module tprs_tick #(
    parameter int unsigned DIV = `TPRS_TICK_CYC
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // restart the divider
    input  wire logic clear,
    // tick out
    output logic      tick
);

    logic [31:0] cnt_r;

    // free-running divider, restarted on clear so intervals start clean
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear)
            cnt_r <= 32'h0000_0000;
        else if (cnt_r == DIV - 1)
            cnt_r <= 32'h0000_0000;
        else
            cnt_r <= cnt_r + 32'h0000_0001;
    end

    assign tick = (cnt_r == DIV - 1) && !clear;

endmodule : tprs_tick

/* File: rtl/tprs_seq.sv */
// tprs_seq: two-pulse record sequencer with AXI4-Lite register port
// assumes trigger and button pins are asynchronous, aclk 40 MHz, sync reset
//
// Functional notes
// - first pulse sets power latch, warm-up loads
// - timer held reset in idle and while any trigger is present in warm-up
// - arm run latch five seconds after first
// - armed second pulse sets run latch, starts
// - second pulse any length; later pulses ignored
// - mains dip resumes at same step
// - pulse transport start, then record input
// - calibration asserted then released for step
// - record thirteen minutes after first calibration
// - repeat calibration after recording interval
// - drop transport run, then record output
// - unlatch pulse clears both latches, power
// - reset input clears timer and switched power
// - local button same; warm-up wait skippable
// - six sensitivity settings, reciprocal calibration level
// - manual transport and record buttons still work
`timescale 1ns/1ps
`include "tprs_regs.svh"

module tprs_seq #(
    parameter int unsigned TICK_DIV   = `TPRS_TICK_CYC,
    parameter int unsigned ARM_TICKS  = `TPRS_ARM_TICKS,
    parameter int unsigned REC_TICKS  = `TPRS_REC_TICKS,
    parameter int unsigned CAL_TICKS  = `TPRS_CAL_TICKS,
    parameter int unsigned PULSE_TICKS = `TPRS_PULSE_TICKS
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // trigger sources and panel inputs (asynchronous)
    input  wire logic        trigger_input_relay,
    input  wire logic        local_start_button,
    input  wire logic        reset_button,
    input  wire logic        manual_start_button,
    input  wire logic        manual_record_button,
    // relay drives
    output logic             power_latch,
    output logic             run_latch,
    output logic             timer_reset,
    output logic             transport_start_pulse,
    output logic             record_pulse,
    output logic             transport_run_output,
    output logic             record_output,
    output logic             calibration_switch,
    output logic             unlatch_output,
    output logic [2:0]       gain_select,
    output logic [3:0]       calibration_step_level
);

    // ---- synchronisers for pin inputs
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;
    logic [4:0] pins;
    assign pins = {manual_record_button, manual_start_button, reset_button,
                   local_start_button, trigger_input_relay};

    // two flops per pin before any logic looks at it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_r <= 5'h00;
            pin_sync_r <= 5'h00;
        end
        else
        begin
            pin_meta_r <= pins;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ---- register file
    logic [31:0] ctrl_r;
    logic [2:0]  sens_r;
    logic        sw_start_r;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic        wr_go;
    logic        ar_go;
    logic [31:0] rdata_nxt;
    logic        rd_hit;

    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_go         = s_axi_arvalid && s_axi_arready;

    // address and data are caught separately, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_hold_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
            end
            else if (wr_go)
                w_hold_r <= 1'b0;
        end
    end

    // register writes; unmapped offsets answer slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r       <= `TPRS_CTRL_RST;
            sens_r       <= `TPRS_SENS_RST;
            sw_start_r   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else
        begin
            sw_start_r <= 1'b0;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (awaddr_r)
                    `TPRS_CTRL_OFS:
                    begin
                        ctrl_r     <= wdata_r;
                        sw_start_r <= wdata_r[`TPRS_CTRL_START_BIT];
                    end
                    `TPRS_SENS_OFS:
                        // out-of-range setting clamps to the least sensitive
                        sens_r <= (wdata_r[2:0] > 3'h5) ? 3'h5 : wdata_r[2:0];
                    `TPRS_STATUS_OFS, `TPRS_STEP_OFS, `TPRS_TICK_OFS:
                        s_axi_bresp <= 2'h0;
                    default:
                        s_axi_bresp <= 2'h2;
                endcase
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ---- sequencer state
    tprs_pkg::tprs_step_e step_r;
    logic        armed_r;
    logic [31:0] wait_r;
    logic        trig_prev_r;
    logic        trig;
    logic        trig_rise;
    logic        seq_reset;
    logic        skip_warm;
    logic        tick;

    assign trig      = pin_sync_r[0] || pin_sync_r[1] || sw_start_r;
    assign trig_rise = trig && !trig_prev_r;
    assign seq_reset = pin_sync_r[2] || ctrl_r[`TPRS_CTRL_RESET_BIT];
    assign skip_warm = ctrl_r[`TPRS_CTRL_SKIP_BIT];

    // slow time base, restarted whenever the program timer is reset
    tprs_tick #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (timer_reset),
        .tick    (tick)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            trig_prev_r <= 1'b0;
        else
            trig_prev_r <= trig;
    end

    // step advance; state lives in flops, so a mains dip that leaves the
    // clock domain powered resumes exactly where it was
    always_ff @(posedge aclk)
    begin
        if (!aresetn || seq_reset)
        begin
            step_r  <= tprs_pkg::TPRS_IDLE;
            armed_r <= 1'b0;
            wait_r  <= 32'h0000_0000;
        end
        else
        begin
            if (tick)
                wait_r <= wait_r + 32'h0000_0001;
            case (step_r)
                tprs_pkg::TPRS_IDLE:
                    if (trig_rise)
                    begin
                        step_r <= tprs_pkg::TPRS_WARM;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_WARM:
                begin
                    if (skip_warm || (tick && wait_r >= ARM_TICKS - 1))
                        armed_r <= 1'b1;
                    if (armed_r && trig_rise)
                    begin
                        step_r <= tprs_pkg::TPRS_START;
                        wait_r <= 32'h0000_0000;
                    end
                end
                tprs_pkg::TPRS_START:
                    if (tick && wait_r >= PULSE_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_RECORD;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_RECORD:
                    if (tick && wait_r >= PULSE_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_CAL1_ON;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_CAL1_ON:
                    if (tick && wait_r >= CAL_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_CAL1_OFF;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_CAL1_OFF:
                    if (tick && wait_r >= CAL_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_RUNNING;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_RUNNING:
                    if (tick && wait_r >= REC_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_CAL2_ON;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_CAL2_ON:
                    if (tick && wait_r >= CAL_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_CAL2_OFF;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_CAL2_OFF:
                    if (tick && wait_r >= CAL_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_STOP;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_STOP:
                    if (tick && wait_r >= PULSE_TICKS - 1)
                    begin
                        step_r <= tprs_pkg::TPRS_UNLATCH;
                        wait_r <= 32'h0000_0000;
                    end
                tprs_pkg::TPRS_UNLATCH:
                    if (tick && wait_r >= PULSE_TICKS - 1)
                    begin
                        step_r  <= tprs_pkg::TPRS_IDLE;
                        armed_r <= 1'b0;
                        wait_r  <= 32'h0000_0000;
                    end
                default:
                    step_r <= tprs_pkg::TPRS_IDLE;
            endcase
        end
    end

    // output decode; triggers beyond the second find no transition
    logic in_run;
    logic stop_phase;
    assign in_run     = !(step_r inside {tprs_pkg::TPRS_IDLE, tprs_pkg::TPRS_WARM});
    assign stop_phase = (step_r == tprs_pkg::TPRS_STOP) && (wait_r >= PULSE_TICKS / 2);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_latch           <= 1'b0;
            run_latch             <= 1'b0;
            timer_reset           <= 1'b1;
            transport_start_pulse <= 1'b0;
            record_pulse          <= 1'b0;
            transport_run_output  <= 1'b0;
            record_output         <= 1'b0;
            calibration_switch    <= 1'b0;
            unlatch_output        <= 1'b0;
            gain_select           <= 3'h0;
            calibration_step_level <= 4'h0;
        end
        else
        begin
            power_latch <= (step_r != tprs_pkg::TPRS_IDLE) && !seq_reset;
            run_latch   <= in_run && !seq_reset;
            // timer held in idle, while any trigger is present in warm-up, or under reset
            timer_reset <= seq_reset || (step_r == tprs_pkg::TPRS_IDLE)
                           || ((step_r == tprs_pkg::TPRS_WARM) && trig);
            // manual buttons or-ed with sequencer pulses
            transport_start_pulse <= (step_r == tprs_pkg::TPRS_START)
                                     || pin_sync_r[3]
                                     || ctrl_r[`TPRS_CTRL_MRUN_BIT];
            record_pulse <= (step_r == tprs_pkg::TPRS_RECORD)
                            || pin_sync_r[4]
                            || ctrl_r[`TPRS_CTRL_MREC_BIT];
            transport_run_output <= in_run && !seq_reset && !stop_phase
                && !(step_r == tprs_pkg::TPRS_UNLATCH);
            record_output <= in_run && !seq_reset
                && (step_r != tprs_pkg::TPRS_START)
                && (step_r != tprs_pkg::TPRS_UNLATCH);
            // reset drops the calibration relay at once, with the latches
            calibration_switch <= ((step_r == tprs_pkg::TPRS_CAL1_ON)
                               || (step_r == tprs_pkg::TPRS_CAL2_ON))
                               && !seq_reset;
            unlatch_output <= (step_r == tprs_pkg::TPRS_UNLATCH);
            // gain divides by 1,2,4,6,8,10; calibration level multiplies back
            gain_select <= sens_r;
            case (sens_r)
                3'h0:    calibration_step_level <= 4'h1;
                3'h1:    calibration_step_level <= 4'h2;
                3'h2:    calibration_step_level <= 4'h4;
                3'h3:    calibration_step_level <= 4'h6;
                3'h4:    calibration_step_level <= 4'h8;
                default: calibration_step_level <= 4'hA;
            endcase
        end
    end

    // ---- register reads
    always_comb
    begin
        rd_hit    = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (s_axi_araddr)
            `TPRS_CTRL_OFS:   rdata_nxt = ctrl_r;
            `TPRS_STATUS_OFS: rdata_nxt = {26'h0, calibration_switch, record_output,
                                           transport_run_output, run_latch,
                                           armed_r, power_latch};
            `TPRS_SENS_OFS:   rdata_nxt = {29'h0, sens_r};
            `TPRS_STEP_OFS:   rdata_nxt = {21'h0, step_r};
            `TPRS_TICK_OFS:   rdata_nxt = wait_r;
            default:          rd_hit    = 1'b0;
        endcase
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end
        else if (ar_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_nxt;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ---- checks
    // the latches stay set for the whole unlatch pulse and fall as it ends
    chk_unlatch_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(unlatch_output) |-> !run_latch && !power_latch)
        else $error("latches still set after unlatch");
    chk_reset_power: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_reset |=> !power_latch && !run_latch && timer_reset)
        else $error("reset did not drop power");
    chk_cal_only_run: assert property (@(posedge aclk) disable iff (!aresetn)
        calibration_switch |-> run_latch && power_latch)
        else $error("calibration outside run");
    chk_run_needs_arm: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(step_r == tprs_pkg::TPRS_START) |-> $past(armed_r))
        else $error("run started unarmed");
    chk_no_retrigger: assert property (@(posedge aclk) disable iff (!aresetn || seq_reset)
        (in_run && step_r != tprs_pkg::TPRS_UNLATCH) |=> step_r != tprs_pkg::TPRS_IDLE)
        else $error("sequence left run early");
    chk_start_first: assert property (@(posedge aclk) disable iff (!aresetn || seq_reset)
        $rose(step_r == tprs_pkg::TPRS_RECORD) |-> $past(step_r) == tprs_pkg::TPRS_START)
        else $error("record pulse before start");
    chk_arm_warm: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(armed_r) |-> skip_warm || step_r == tprs_pkg::TPRS_WARM)
        else $error("armed outside warm-up");
    chk_cal_level: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (sens_r == 3'h5 && $stable(sens_r)) |=> calibration_step_level == 4'hA)
        else $error("calibration level not reciprocal");

endmodule : tprs_seq

/* File: verif/tprs_trig_src.sv */
// tprs_trig_src: firing-control line model, one trigger pulse per request
// assumes the bench raises go for one cycle with the pulse length in cycles
`timescale 1ns/1ps
module tprs_trig_src (
    // clock
    input  wire logic       aclk,
    // request from the bench
    input  wire logic       go,
    input  wire logic [7:0] len,
    // trigger line, low between pulses
    output wire logic       trig
);
    logic [7:0] cnt_r = 8'h00;
    // pulse width and spacing come from the bench, kept short and late enough
    always_ff @(posedge aclk)
        cnt_r <= go ? len : ((cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00);
    assign trig = (cnt_r != 8'h00);
endmodule : tprs_trig_src

/* File: verif/tb_two_pulse_record_sequencer.sv */
// tb_two_pulse_record_sequencer: self-checking bench of the record sequencer
// assumes tprs_seq with shortened counts and the trigger line model beside it
`timescale 1ns/1ps
`include "tprs_regs.svh"
module tb_two_pulse_record_sequencer;
    localparam int TD = 4, RT = 20, CT = 3;
    logic aclk = 1'h0, aresetn = 1'h0, go = 1'h0, lbtn = 1'h0, rbtn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic mst = 1'h0, mrec = 1'h0, awready, wready, bvalid, arready, rvalid, trig;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, len = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF, clvl;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] gsel;
    logic pwr, run, trst, xsp, rcp, xrun, rec, cal, unl;
    logic [6:0] pv = 7'h00;
    int n_mismatch = 0, compares = 0, ncyc = 0, n, k, r;
    int lvl[6] = '{1, 2, 4, 6, 8, 10};
    int exp_q[$], obs_q[$], tq[$];
    wire [6:0] evv = {unl, ~rec, ~xrun, ~cal, cal, rcp, xsp};

    tprs_seq #(.TICK_DIV(TD), .ARM_TICKS(5), .REC_TICKS(RT), .CAL_TICKS(CT), .PULSE_TICKS(2)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trigger_input_relay(trig), .local_start_button(lbtn), .reset_button(rbtn),
        .manual_start_button(mst), .manual_record_button(mrec), .power_latch(pwr),
        .run_latch(run), .timer_reset(trst), .transport_start_pulse(xsp), .record_pulse(rcp),
        .transport_run_output(xrun), .record_output(rec), .calibration_switch(cal),
        .unlatch_output(unl), .gain_select(gsel), .calibration_step_level(clvl));
    tprs_trig_src line (.aclk(aclk), .go(go), .len(len), .trig(trig));

    initial
    begin
        forever #12.5 aclk = ~aclk;
    end
    // event log: code is bit index plus one, with the cycle it was seen in
    always @(posedge aclk)
    begin
        ncyc++;
        for (int i = 0; i < 7; i++)
            if (aresetn && evv[i] && !pv[i])
            begin
                obs_q.push_back(i + 1);
                tq.push_back(ncyc);
            end
        pv <= evv;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge aclk);
    endtask : cyc
    task automatic fire(input logic [7:0] l);
        go <= 1'h1;
        len <= l;
        @(posedge aclk);
        go <= 1'h0;
    endtask : fire
    // write: address and data offered together, bready held until the answer
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
        int c;
        c = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            c++;
        end
        while (bvalid !== 1'h1 && c < 200);
        s = bresp;
        bready <= 1'h0;
        if (c >= 200) n_mismatch++;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
        int c;
        c = 0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            c++;
        end
        while (rvalid !== 1'h1 && c < 200);
        d = rdata;
        s = rresp;
        rready <= 1'h0;
        if (c >= 200) n_mismatch++;
    endtask : axr
    task automatic results();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        cyc(20000);
        n_mismatch++;
        results();
    end
    initial
    begin
        void'($urandom(32'h390f1728));
        exp_q = '{1, 2, 3, 4, 3, 4, 5, 6, 7};
        cyc(15);
        chk({pwr, run, trst}, 3'h1, "reset");
        cyc(1);
        aresetn <= 1'h1;
        axr(`TPRS_CTRL_OFS, rd, rs);
        chk(rd, `TPRS_CTRL_RST, "ctrl reset value");
        cyc(1);
        axr(8'h40, rd, rs);
        chk(rs, 2'h2, "unmapped read");
        axw(8'h44, 32'h1, rs);
        chk(rs, 2'h2, "unmapped write");
        cyc(1);
        // every sensitivity setting, starting at a random one
        r = $urandom % 6;
        for (int i = 0; i < 6; i++)
        begin
            k = (i + r) % 6;
            axw(`TPRS_SENS_OFS, k, rs);
            cyc(3);
            chk({gsel, clvl}, {k[2:0], 4'(lvl[k])}, "sens");
        end
        mst <= 1'h1;
        mrec <= 1'h1;
        cyc(6);
        chk({xsp, rcp}, 2'h3, "manual");
        mst <= 1'h0;
        mrec <= 1'h0;
        cyc(8);
        obs_q.delete();
        tq.delete();
        // remote run: short first pulse, an early one, then a random-length start
        fire(8'h08);
        cyc(6);
        chk({pwr, trst}, 2'h3, "first pulse");
        cyc(8);
        chk({pwr, trst}, 2'h2, "warm-up");
        fire(8'h03);
        cyc(6);
        chk(run, 1'h0, "early pulse");
        cyc(20);
        axr(`TPRS_STATUS_OFS, rd, rs);
        chk(rd[`TPRS_ST_ARM_BIT], 1'h1, "armed");
        fire(8'(2 + $urandom % 30));
        cyc(8);
        chk({pwr, run}, 2'h3, "started");
        cyc(40);
        fire(8'h04);
        for (n = 0; pwr === 1'h1 && n < 600; n++) cyc(1);
        cyc(4);
        chk({pwr, run, xrun, rec}, 4'h0, "shut off");
        chk(obs_q.size(), exp_q.size(), "event count");
        foreach (exp_q[i]) chk(obs_q[i], exp_q[i], "event order");
        n = tq[4] - tq[3];
        chk(n >= RT * TD && n <= (RT + CT + 1) * TD, 1'h1, "rec time");
        // local button with warm-up skipped, then the reset button mid-run
        axw(`TPRS_CTRL_OFS, 32'h1 << `TPRS_CTRL_SKIP_BIT, rs);
        lbtn <= 1'h1;
        cyc(4);
        lbtn <= 1'h0;
        cyc(8);
        lbtn <= 1'h1;
        cyc(4);
        lbtn <= 1'h0;
        cyc(8);
        chk({pwr, run}, 2'h3, "local start");
        cyc(20);
        rbtn <= 1'h1;
        cyc(6);
        chk({pwr, run, xrun, rec}, 4'h0, "reset button");
        rbtn <= 1'h0;
        cyc(4);
        results();
    end
endmodule : tb_two_pulse_record_sequencer
